/* shared/stm_pkg.sv */
// Package holding constants and types for the 16-bit standard timer
// Summary of operation
// - Pause bit holds count, clearing resumes
// - Clock select picks one of seven sources
// - Reserved clock code stops the counter
// - On rising clears and starts, falling holds
// - On rising restores compare output level
// - Mode field selects four operating modes
// - Comparator A match drives pin per function
// - Match level equal to initial changes nothing
// - PWM mode pin function selects behaviour
// - Capture mode pin function selects trigger edge
// - Output control sets initial or active level
// - Polarity bit inverts output pin except in timer mode
// - Swap bit chooses period and duty roles
// - Clear select high clears on A match
// - Clear select low clears on P match/overflow
// - Clear select ignored in PWM, pulse, capture
// - Counter readable as two bytes, reset zero
// - Compare A readable/writable bytes, reset zero
// - Compare P matches counter high byte
// - Off stops counter; pause stays powered
package stm_pkg;
	localparam logic [2:0] STM_ADDR_CTRL0  = 3'h0;
	localparam logic [2:0] STM_ADDR_CTRL1  = 3'h1;
	localparam logic [2:0] STM_ADDR_CNT_LO = 3'h2;
	localparam logic [2:0] STM_ADDR_CNT_HI = 3'h3;
	localparam logic [2:0] STM_ADDR_CMPA_LO = 3'h4;
	localparam logic [2:0] STM_ADDR_CMPA_HI = 3'h5;
	localparam logic [2:0] STM_ADDR_CMPP   = 3'h6;

	localparam logic [2:0] STM_CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] STM_CK_SYS      = 3'h1;
	localparam logic [2:0] STM_CK_HIGH16   = 3'h2;
	localparam logic [2:0] STM_CK_HIGH64   = 3'h3;
	localparam logic [2:0] STM_CK_TBC      = 3'h4;
	localparam logic [2:0] STM_CK_EXT_RISE = 3'h6;
	localparam logic [2:0] STM_CK_EXT_FALL = 3'h7;

	localparam logic [1:0] STM_MODE_CMP  = 2'h0;
	localparam logic [1:0] STM_MODE_CAP  = 2'h1;
	localparam logic [1:0] STM_MODE_PWM  = 2'h2;
	localparam logic [1:0] STM_MODE_TMR  = 2'h3;

	localparam logic [1:0] STM_IO_00 = 2'h0;
	localparam logic [1:0] STM_IO_01 = 2'h1;
	localparam logic [1:0] STM_IO_10 = 2'h2;
	localparam logic [1:0] STM_IO_11 = 2'h3;

	localparam logic [1:0] STM_DIV4_LAST  = 2'h3;
	localparam logic [3:0] STM_DIV16_LAST = 4'hF;
	localparam logic [5:0] STM_DIV64_LAST = 6'h3F;
	localparam logic [7:0] STM_BYTE_ZERO  = 8'h00;
	localparam logic [15:0] STM_CNT_ONE   = 16'h0001;
	localparam logic [15:0] STM_CNT_MAX   = 16'hFFFF;

	typedef struct packed {
		logic       pause_ctrl;
		logic [2:0] clock_select;
		logic       counter_on_off;
	} stm_ctrl0_t;

	typedef struct packed {
		logic [1:0] op_mode_select;
		logic [1:0] pin_function_select;
		logic       output_control;
		logic       output_invert;
		logic       period_duty_swap;
		logic       clear_select;
	} stm_ctrl1_t;

	localparam stm_ctrl0_t STM_CTRL0_RST = '{1'b0, 3'h0, 1'b0};
	localparam stm_ctrl1_t STM_CTRL1_RST = '{2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage : stm_pkg

/* verilog/stm_timer.sv */
// Design of the 16-bit standard timer with its register port
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module stm_timer
	import stm_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// Register port
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [7:0]  o_rdata,
	// Clock sources, one-cycle enables
	input  wire logic        i_high_clock_en,
	input  wire logic        i_timebase_clock_en,
	// Pins
	input  wire logic        i_ext_clock_pin,
	input  wire logic        i_timer_pin_a,
	input  wire logic        i_timer_pin_b,
	output var  logic        o_timer_pin,
	output var  logic        o_timer_pin_oe,
	output var  logic        o_capture,
	output var  logic        o_power_on
);
	stm_ctrl0_t  ctrl0_q;
	stm_ctrl1_t  ctrl1_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] cmpa_q;
	logic [7:0]  cmpp_q;
	logic [15:0] cap_q;
	logic [7:0]  rdata_q;
	logic        on_q;
	logic        pin_q;
	logic        pin_d;
	logic        pin_oe_q;
	logic        cap_pulse_q;
	logic        ext_q;
	logic        pa_q;
	logic        pb_q;
	logic [1:0]  div4_q;
	logic [3:0]  div16_q;
	logic [5:0]  div64_q;

	// Register decode
	wire wr_c0  = i_wr && (i_addr == STM_ADDR_CTRL0);
	wire wr_c1  = i_wr && (i_addr == STM_ADDR_CTRL1);
	wire wr_al  = i_wr && (i_addr == STM_ADDR_CMPA_LO);
	wire wr_ah  = i_wr && (i_addr == STM_ADDR_CMPA_HI);
	wire wr_p   = i_wr && (i_addr == STM_ADDR_CMPP);
	wire [4:0] c0_bits = ctrl0_q;
	wire [7:0] rd_mux =
		(i_addr == STM_ADDR_CTRL0)   ? {c0_bits, 3'h0} :
		(i_addr == STM_ADDR_CTRL1)   ? ctrl1_q :
		(i_addr == STM_ADDR_CNT_LO)  ? cnt_q[7:0] :
		(i_addr == STM_ADDR_CNT_HI)  ? cnt_q[15:8] :
		(i_addr == STM_ADDR_CMPA_LO) ? cmpa_q[7:0] :
		(i_addr == STM_ADDR_CMPA_HI) ? cmpa_q[15:8] :
		(i_addr == STM_ADDR_CMPP)    ? cmpp_q : STM_BYTE_ZERO;

	// Control fields
	wire        run      = ctrl0_q.counter_on_off;
	wire        on_rise  = run && !on_q;
	wire [1:0]  mode     = ctrl1_q.op_mode_select;
	wire [1:0]  pfs      = ctrl1_q.pin_function_select;
	wire        oc       = ctrl1_q.output_control;

	// Clock source select
	wire tick_div4  = (div4_q == STM_DIV4_LAST);
	wire tick_h16   = i_high_clock_en && (div16_q == STM_DIV16_LAST);
	wire tick_h64   = i_high_clock_en && (div64_q == STM_DIV64_LAST);
	wire ext_rise   = i_ext_clock_pin && !ext_q;
	wire ext_fall   = !i_ext_clock_pin && ext_q;
	wire tick =
		(ctrl0_q.clock_select == STM_CK_SYS_DIV4) ? tick_div4 :
		(ctrl0_q.clock_select == STM_CK_SYS)      ? 1'b1 :
		(ctrl0_q.clock_select == STM_CK_HIGH16)   ? tick_h16 :
		(ctrl0_q.clock_select == STM_CK_HIGH64)   ? tick_h64 :
		(ctrl0_q.clock_select == STM_CK_TBC)      ? i_timebase_clock_en :
		(ctrl0_q.clock_select == STM_CK_EXT_RISE) ? ext_rise :
		(ctrl0_q.clock_select == STM_CK_EXT_FALL) ? ext_fall : 1'b0;
	wire step = run && !ctrl0_q.pause_ctrl && tick;

	// Comparators on the counter's next value
	wire [15:0] cnt_inc   = cnt_q + STM_CNT_ONE;
	wire        match_a   = step && (cnt_inc == cmpa_q);
	wire        match_p   = step && (cmpp_q != STM_BYTE_ZERO)
		&& (cnt_inc[15:8] == cmpp_q) && (cnt_inc[7:0] == STM_BYTE_ZERO);
	wire        overflow  = step && (cnt_q == STM_CNT_MAX);
	wire        pwm_mode  = (mode == STM_MODE_PWM);
	wire        pulse_sel = pwm_mode && (pfs == STM_IO_11);
	wire        clr_cmp   = ctrl1_q.clear_select ? match_a
		: (match_p || (cmpp_q == STM_BYTE_ZERO && overflow));
	wire        clr_pwm   = ctrl1_q.period_duty_swap ? match_a : match_p;
	wire        clr_any   = pulse_sel ? 1'b0 :
		pwm_mode ? clr_pwm :
		(mode == STM_MODE_CAP) ? 1'b0 : clr_cmp;

	// PWM duty compare against the non-period register
	wire        duty_hit  = ctrl1_q.period_duty_swap
		? (cnt_q[15:8] >= cmpp_q) : (cnt_q >= cmpa_q);
	wire        pwm_act   = !duty_hit;

	// Capture trigger edges
	wire edge_rise = (i_timer_pin_a && !pa_q) || (i_timer_pin_b && !pb_q);
	wire edge_fall = (!i_timer_pin_a && pa_q) || (!i_timer_pin_b && pb_q);
	wire cap_hit =
		(pfs == STM_IO_00) ? edge_rise :
		(pfs == STM_IO_01) ? edge_fall :
		(pfs == STM_IO_10) ? (edge_rise || edge_fall) : 1'b0;
	wire cap_ev = run && (mode == STM_MODE_CAP) && cap_hit;

	// Counter next value
	always_comb begin
		cnt_d = cnt_q;
		if (on_rise) begin
			cnt_d = 16'h0000;
		end else if (step) begin
			cnt_d = clr_any ? 16'h0000 : cnt_inc;
		end
	end

	// Pin level before polarity
	always_comb begin
		pin_d = pin_q;
		case (mode)
			STM_MODE_CMP: begin
				if (on_rise) begin
					pin_d = oc;
				end else if (match_a) begin
					case (pfs)
						STM_IO_01: pin_d = 1'b0;
						STM_IO_10: pin_d = 1'b1;
						STM_IO_11: pin_d = !pin_q;
						default:   pin_d = pin_q;
					endcase
				end
			end
			STM_MODE_PWM: begin
				case (pfs)
					STM_IO_00: pin_d = !oc;
					STM_IO_01: pin_d = oc;
					STM_IO_10: pin_d = pwm_act ? oc : !oc;
					default:   pin_d = (run && !match_a) ? oc : !oc;
				endcase
			end
			default: pin_d = pin_q;
		endcase
	end

	// Registers and software access
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl0_q <= STM_CTRL0_RST;
			ctrl1_q <= STM_CTRL1_RST;
			cmpa_q  <= 16'h0000;
			cmpp_q  <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			if (wr_c0) begin
				ctrl0_q <= i_wdata[7:3];
			end else if (match_a && pulse_sel) begin
				ctrl0_q.counter_on_off <= 1'b0;
			end
			if (wr_c1) begin
				ctrl1_q <= i_wdata;
			end
			if (wr_al) begin
				cmpa_q[7:0] <= i_wdata;
			end
			if (wr_ah) begin
				cmpa_q[15:8] <= i_wdata;
			end
			if (wr_p) begin
				cmpp_q <= i_wdata;
			end
			rdata_q <= i_rd ? rd_mux : STM_BYTE_ZERO;
		end
	end

	// Counter, dividers and pin state
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q       <= 16'h0000;
			on_q        <= 1'b0;
			pin_q       <= 1'b0;
			pin_oe_q    <= 1'b0;
			o_timer_pin <= 1'b0;
			cap_q       <= 16'h0000;
			cap_pulse_q <= 1'b0;
			ext_q       <= 1'b0;
			pa_q        <= 1'b0;
			pb_q        <= 1'b0;
			div4_q      <= 2'h0;
			div16_q     <= 4'h0;
			div64_q     <= 6'h0;
		end else begin
			cnt_q       <= cnt_d;
			on_q        <= run;
			pin_q       <= pin_d;
			pin_oe_q    <= (mode == STM_MODE_CMP) || pwm_mode;
			o_timer_pin <= (mode == STM_MODE_TMR) ? 1'b0
				: (pin_d ^ ctrl1_q.output_invert);
			cap_pulse_q <= cap_ev;
			if (cap_ev) begin
				cap_q <= cnt_q;
			end
			ext_q       <= i_ext_clock_pin;
			pa_q        <= i_timer_pin_a;
			pb_q        <= i_timer_pin_b;
			div4_q      <= div4_q + 2'h1;
			if (i_high_clock_en) begin
				div16_q <= div16_q + 4'h1;
				div64_q <= div64_q + 6'h1;
			end
		end
	end

	assign o_rdata        = rdata_q;
	assign o_timer_pin_oe = pin_oe_q;
	assign o_capture      = cap_pulse_q;
	assign o_power_on     = on_q;
endmodule : stm_timer
`default_nettype wire

/* tb/stm_timer_assertions.sv */
// Checker on the timer's ports
`timescale 1ns/1ns
`default_nettype none
module stm_timer_assertions
	import stm_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_rstn,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_timer_pin_a,
	input wire logic       o_timer_pin,
	input wire logic       o_timer_pin_oe,
	input wire logic       o_capture,
	input wire logic       o_power_on
);
	stm_ctrl1_t c1_q;
	wire        w1  = i_wr && i_addr == STM_ADDR_CTRL1;
	wire        cap = c1_q.op_mode_select == STM_MODE_CAP;
	wire        cpd = cap && c1_q.pin_function_select == STM_IO_11;
	wire        tmr = c1_q.op_mode_select == STM_MODE_TMR;
	// Shadow of the mode register
	always_ff @(posedge i_clock or negedge i_rstn)
		if (!i_rstn) c1_q <= STM_CTRL1_RST;
		else if (w1) c1_q <= i_wdata;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_none; i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00; endproperty
	a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
	property p_on;
		i_wr && i_addr == STM_ADDR_CTRL0 |-> ##2 o_power_on == $past(i_wdata[3], 2);
	endproperty
	a_on: assert property (p_on) else $error("power state wrong");
	property p_oe_tmr; tmr && $past(tmr) |-> !o_timer_pin_oe && !o_timer_pin; endproperty
	a_oe_tmr: assert property (p_oe_tmr) else $error("pin active in timer mode");
	property p_oe_on;
		$past(i_rstn) && !c1_q[6] && !$past(c1_q[6]) |-> o_timer_pin_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin enable missing");
	property p_cap_off; !cap && !$past(cap) && !$past(cap, 2) |-> !o_capture; endproperty
	a_cap_off: assert property (p_cap_off) else $error("capture outside mode");
	property p_cap_dis; cpd && $past(cpd) && $past(cpd, 2) |-> !o_capture; endproperty
	a_cap_dis: assert property (p_cap_dis) else $error("capture while disabled");
	property p_cap_rise;
		cap && c1_q.pin_function_select == STM_IO_00 && $rose(i_timer_pin_a) |-> ##[0:2] o_capture;
	endproperty
	a_cap_rise: assert property (p_cap_rise) else $error("rising capture missing");
	property p_pin_init;
		i_wr && i_addr == STM_ADDR_CTRL0 && i_wdata[3] && !o_power_on && c1_q[7:6] == STM_MODE_CMP
		|-> ##[2:3] o_timer_pin == (c1_q.output_control ^ c1_q.output_invert);
	endproperty
	a_pin_init: assert property (p_pin_init) else $error("pin not at initial");
endmodule : stm_timer_assertions
`default_nettype wire

/* tb/stm_timer_tb.sv */
// Testbench for the timer
`timescale 1ns/1ns
`default_nettype none
module stm_timer_tb;
	import stm_pkg::*;
	logic       i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0;
	logic       hce = 0, tbe = 0, ext = 0, pa = 0, pb = 0, rd_seen = 0;
	logic [2:0] i_addr = 0;
	logic [7:0] i_wdata = 0;
	logic [7:0] o_rdata;
	logic       pin, oe, cap, pwr;
	logic [7:0] exq[$];
	int         err_count = 0, tests_run = 0, caps = 0;
	always #4 i_clock = ~i_clock;
	stm_timer u_dut (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_high_clock_en(hce), .i_timebase_clock_en(tbe), .i_ext_clock_pin(ext),
		.i_timer_pin_a(pa), .i_timer_pin_b(pb), .o_timer_pin(pin), .o_timer_pin_oe(oe),
		.o_capture(cap), .o_power_on(pwr));
	task automatic test_done();
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge i_clock);
	endtask : cyc
	task automatic wr(logic [2:0] a, logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		cyc(1);
		i_wr <= 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(logic [2:0] a, logic [7:0] e);
		exq.push_back(e);
		i_addr <= a;
		i_rd <= 1'b1;
		cyc(1);
		i_rd <= 1'b0;
		cyc(1);
	endtask : rd
	task automatic pchk(logic e);
		cyc(3);
		@(negedge i_clock);
		chk("pin", {7'h00, e}, {7'h00, pin});
		@(posedge i_clock);
	endtask : pchk
	task automatic tg(int n);
		repeat (n) begin
			ext <= ~ext;
			cyc(3);
		end
	endtask : tg
	task automatic pu(int n);
		repeat (n) begin
			hce <= 1'b1;
			tbe <= 1'b1;
			cyc(1);
			hce <= 1'b0;
			tbe <= 1'b0;
			cyc(1);
		end
	endtask : pu
	// Read data are checked in the cycle after the strobe
	always @(negedge i_clock) begin
		if (rd_seen) chk("rdata", exq.pop_front(), o_rdata);
		rd_seen = i_rd;
		if (cap === 1'b1) caps++;
	end
	initial begin
		cyc(60000);
		err_count++;
		test_done();
	end
	initial begin
		logic [7:0] r;
		void'($urandom(32'hFC16));
		cyc(8);
		i_rstn <= 1'b1;
		cyc(1);
		for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
		wr(STM_ADDR_CNT_LO, 8'hA5);
		rd(STM_ADDR_CNT_LO, 8'h00);
		r = 8'($urandom);
		wr(STM_ADDR_CMPA_LO, r);
		wr(STM_ADDR_CMPA_HI, ~r);
		wr(STM_ADDR_CMPP, r);
		rd(STM_ADDR_CMPA_LO, r);
		rd(STM_ADDR_CMPA_HI, ~r);
		rd(STM_ADDR_CMPP, r);
		$display("registers done");
		wr(STM_ADDR_CTRL1, {STM_MODE_TMR, 6'h00});
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_RISE, 4'h8});
		tg(3);
		rd(STM_ADDR_CNT_LO, 8'h02);
		wr(STM_ADDR_CTRL0, {1'b1, STM_CK_EXT_RISE, 4'h8});
		tg(3);
		rd(STM_ADDR_CNT_LO, 8'h02);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_FALL, 4'h8});
		tg(3);
		rd(STM_ADDR_CNT_LO, 8'h03);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_FALL, 4'h0});
		tg(3);
		rd(STM_ADDR_CNT_LO, 8'h03);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_FALL, 4'h8});
		rd(STM_ADDR_CNT_LO, 8'h00);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_TBC, 4'h8});
		pu(5);
		rd(STM_ADDR_CNT_LO, 8'h05);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_HIGH16, 4'h8});
		pu(32);
		rd(STM_ADDR_CNT_LO, 8'h07);
		wr(STM_ADDR_CTRL0, {1'b0, STM_CK_HIGH64, 4'h8});
		pu(64);
		rd(STM_ADDR_CNT_LO, 8'h08);
		wr(STM_ADDR_CTRL0, {1'b0, 3'h5, 4'h8});
		pu(64);
		tg(2);
		rd(STM_ADDR_CNT_LO, 8'h08);
		$display("counting done");
		for (int i = 0; i < 4; i++) begin
			wr(STM_ADDR_CTRL0, 8'h00);
			wr(STM_ADDR_CMPA_LO, i[0] ? 8'h05 : 8'h00);
			wr(STM_ADDR_CMPA_HI, i[0] ? 8'h00 : 8'h02);
			wr(STM_ADDR_CMPP, i[0] ? 8'h00 : 8'h01);
			wr(STM_ADDR_CTRL1, {STM_MODE_TMR, 5'h00, i[0]});
			wr(STM_ADDR_CTRL0, {3'h0, i[1], 4'h8});
			cyc(1100);
			rd(STM_ADDR_CNT_HI, 8'h00);
		end
		$display("clearing done");
		wr(STM_ADDR_CMPA_LO, 8'h03);
		for (int i = 0; i < 16; i++) begin
			wr(STM_ADDR_CTRL0, 8'h00);
			wr(STM_ADDR_CTRL1, {STM_MODE_CMP, i[1:0], i[2], i[3], 2'h1});
			wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_RISE, 4'h8});
			pchk(i[2] ^ i[3]);
			tg(6);
			pchk((i[1:0] == 0 ? i[2] : i[1:0] == 3 ? ~i[2] : i[1]) ^ i[3]);
			tg(6);
			pchk((i[0] == i[1] ? i[2] : i[1]) ^ i[3]);
		end
		$display("compare output done");
		for (int i = 0; i < 5; i++) begin
			wr(STM_ADDR_CTRL0, 8'h00);
			wr(STM_ADDR_CMPP, i == 4 ? 8'h01 : 8'h00);
			wr(STM_ADDR_CTRL1, i == 4 ? {STM_MODE_PWM, 6'h2A} : {STM_MODE_PWM, i[1:0], 4'h8});
			wr(STM_ADDR_CTRL0, {1'b0, STM_CK_EXT_RISE, 4'h8});
			pchk(i != 0);
			tg(6);
			pchk(i == 1 || i == 4);
		end
		$display("pwm done");
		for (int i = 0; i < 4; i++) begin
			wr(STM_ADDR_CTRL0, 8'h00);
			wr(STM_ADDR_CTRL1, {STM_MODE_CAP, i[1:0], 4'h0});
			wr(STM_ADDR_CTRL0, {1'b0, STM_CK_SYS, 4'h8});
			caps = 0;
			for (int k = 1; k < 5; k++) begin
				{pb, pa} <= 2'((k & 3) ^ ((k & 3) >> 1));
				cyc(4);
			end
			cyc(4);
			chk("captures", 8'(i == 3 ? 0 : i == 2 ? 4 : 2), 8'(caps));
		end
		$display("capture done");
		test_done();
	end
endmodule : stm_timer_tb
bind stm_timer stm_timer_assertions u_chk (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_timer_pin_a, .o_timer_pin, .o_timer_pin_oe, .o_capture, .o_power_on);
`default_nettype wire
